// [common/i2cdc_pkg.sv]
package i2cdc_pkg;
  localparam int unsigned CLK_NS      = 25;
  localparam int unsigned SCL_HALF_NS = 100;
  localparam int unsigned SCL_HALF_CYC = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;
  // Offsets are word indices; byte address is four times that
  localparam logic [9:0]  DATA_IDX  = 10'h0ca;
  localparam logic [9:0]  CTRL_IDX  = 10'h0cb;
  localparam logic [11:0] DATA_ADDR = {DATA_IDX, 2'b00};
  localparam logic [11:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
  localparam logic [7:0]  DATA_RST  = 8'h00;
  localparam int IEN_B  = 7;
  localparam int BUS_ENABLE_BIT_B = 6;
  localparam int STA_B  = 5;
  localparam int STP_B  = 4;
  localparam int FLG_B  = 3;
  localparam int ACK_B  = 2;
  localparam logic [7:0] SC_BERR = 8'h00, SC_STA = 8'h08, SC_RSTA = 8'h10,
    SC_AW_A = 8'h18, SC_AW_N = 8'h20, SC_DT_A = 8'h28, SC_DT_N = 8'h30,
    SC_ARB = 8'h38, SC_AR_A = 8'h40, SC_AR_N = 8'h48, SC_DR_A = 8'h50,
    SC_DR_N = 8'h58, SC_SW = 8'h60, SC_GC = 8'h70, SC_SD_A = 8'h80,
    SC_SD_N = 8'h88, SC_GD_A = 8'h90, SC_GD_N = 8'h98, SC_SSTP = 8'ha0,
    SC_SR = 8'ha8, SC_ST_A = 8'hb8, SC_ST_N = 8'hc0, SC_ST_L = 8'hc8,
    SC_IDLE = 8'hf8;
  typedef struct packed {
    logic irq_en;
    logic bus_en;
    logic start_req;
    logic stop_req;
    logic flag;
    logic ack_ctl;
  } i2cdc_ctrl_type;
  localparam i2cdc_ctrl_type CTRL_RST = '0;
  typedef struct packed {
    logic       wr_data;
    logic       wr_ctrl;
    logic [7:0] wdata;
  } i2cdc_req_type;
  typedef enum logic [2:0] {S_IDLE, S_START, S_BIT, S_WAIT, S_STOP, S_RSTART}
    i2cdc_state_type;
endpackage

// [hdl/i2cdc_sync.sv]
`timescale 1ns/100ps
module i2cdc_sync #(
  parameter int unsigned W = 2
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rstn,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_r;
  // Lines idle high, so the chain resets to ones
  always_ff @(posedge i_mclk or negedge i_rstn)
    if (!i_rstn)
    begin
      meta_r <= '1;
      o_q    <= '1;
    end
    else
    begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
endmodule

// [hdl/i2cdc_avs.sv]
`timescale 1ns/100ps
module i2cdc_avs (
  input  wire logic                    i_mclk,
  input  wire logic                    i_rstn,
  input  wire logic [11:0]             i_avs_address,
  input  wire logic                    i_avs_read,
  input  wire logic                    i_avs_write,
  input  wire logic [31:0]             i_avs_writedata,
  input  wire logic [3:0]              i_avs_byteenable,
  output logic      [31:0]             o_avs_readdata,
  output logic                         o_avs_waitrequest,
  input  wire logic [7:0]              i_data_val,
  input  wire logic [7:0]              i_ctrl_val,
  output i2cdc_pkg::i2cdc_req_type     o_req
);
  logic       ack_r;
  wire        req     = i_avs_read | i_avs_write;
  wire        sel_d   = i_avs_address == i2cdc_pkg::DATA_ADDR;
  wire        sel_c   = i_avs_address == i2cdc_pkg::CTRL_ADDR;
  wire        wr_ok   = i_avs_write & ack_r & i_avs_byteenable[0];
  // Unmapped addresses read zero and swallow writes
  wire [7:0]  rd_mux  = sel_d ? i_data_val : (sel_c ? i_ctrl_val : 8'h00);
  // One wait state; write lands on the edge where waitrequest is low
  assign o_avs_waitrequest = req & ~ack_r;
  assign o_req.wr_data     = wr_ok & sel_d;
  assign o_req.wr_ctrl     = wr_ok & sel_c;
  assign o_req.wdata       = i_avs_writedata[7:0];
  always_ff @(posedge i_mclk or negedge i_rstn)
    if (!i_rstn)
    begin
      ack_r          <= 1'b0;
      o_avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= req & ~ack_r;
      if (i_avs_read & ~ack_r)
        o_avs_readdata <= {24'h00_0000, rd_mux};
    end
endmodule

// [hdl/i2cdc_top.sv]
`timescale 1ns/100ps
module i2cdc_top #(
  parameter int unsigned HALF_CYC = i2cdc_pkg::SCL_HALF_CYC
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rstn,
  input  wire logic [11:0] i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic [6:0]  i_own_addr,
  input  wire logic        i_gcall_en,
  input  wire logic        i_scl,
  output logic             o_scl,
  output logic             o_scl_oen,
  input  wire logic        i_sda,
  output logic             o_sda,
  output logic             o_sda_oen,
  output logic             o_irq,
  output logic      [7:0]  o_status_code
);
  if (HALF_CYC < 2 || HALF_CYC > 255)
  begin : g_chk
    $error("HALF_CYC must lie in 2..255");
  end

  ////////////////////////////////////////////////////////////////////////
  logic rst_meta_r;
  logic rstn_r;
  always_ff @(posedge i_mclk or negedge i_rstn)
    if (!i_rstn)
    begin
      rst_meta_r <= 1'b0;
      rstn_r     <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rstn_r     <= rst_meta_r;
    end

  ////////////////////////////////////////////////////////////////////////
  i2cdc_pkg::i2cdc_ctrl_type  ctrl_r, ctrl_nxt;
  i2cdc_pkg::i2cdc_state_type state_r, state_nxt;
  i2cdc_pkg::i2cdc_req_type   req;
  logic [7:0] data_r, data_nxt, shift_r, shift_nxt, status_r, status_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [1:0] lines_s;
  logic scl_p_r, sda_p_r, busy_r;
  logic master_r, master_nxt, slave_r, slave_nxt, tx_r, tx_nxt;
  logic aph_r, aph_nxt, gc_r, gc_nxt, lost_r, lost_nxt, done_r, done_nxt;
  logic moved_r, moved_nxt, ackin_r, ackin_nxt;
  logic scl_lo_r, scl_lo_nxt, sda_lo_r, sda_lo_nxt;
  logic evt, sta_clr, stp_clr;
  logic [7:0] evt_code;

  i2cdc_avs u_avs (
    .i_mclk            (i_mclk),
    .i_rstn            (rstn_r),
    .i_avs_address     (i_avs_address),
    .i_avs_read        (i_avs_read),
    .i_avs_write       (i_avs_write),
    .i_avs_writedata   (i_avs_writedata),
    .i_avs_byteenable  (i_avs_byteenable),
    .o_avs_readdata    (o_avs_readdata),
    .o_avs_waitrequest (o_avs_waitrequest),
    .i_data_val        (data_r),
    .i_ctrl_val        ({ctrl_r, 2'b00}),
    .o_req             (req)
  );

  i2cdc_sync #(.W(2)) u_sync (
    .i_mclk (i_mclk),
    .i_rstn (rstn_r),
    .i_d    ({i_scl, i_sda}),
    .o_q    (lines_s)
  );

  ////////////////////////////////////////////////////////////////////////
  wire en        = ctrl_r.bus_en;
  wire scl_s     = lines_s[1] | ~en;
  wire sda_s     = lines_s[0] | ~en;
  wire rise      = scl_s & ~scl_p_r;
  wire fall      = ~scl_s & scl_p_r;
  wire start_det = scl_s & scl_p_r & sda_p_r & ~sda_s;
  wire stop_det  = scl_s & scl_p_r & ~sda_p_r & sda_s;
  wire tick      = cnt_r == 8'(HALF_CYC - 1);
  wire rw        = shift_r[0];
  wire own_hit   = shift_r[7:1] == i_own_addr;
  wire gc_hit    = shift_r[7:1] == 7'h00 && i_gcall_en;
  // Address only claimed with acknowledge enabled
  wire addr_hit  = ctrl_r.ack_ctl & (own_hit | gc_hit);
  wire resume    = state_r == i2cdc_pkg::S_WAIT && !ctrl_r.flag;
  wire flag_clr  = req.wr_ctrl & ~req.wdata[i2cdc_pkg::FLG_B] & ctrl_r.flag;

  // Status for the end of a byte, after the acknowledge clock
  function automatic logic [7:0] end_code(input logic lost, input logic mst,
    input logic aph, input logic tx, input logic gc, input logic rwb,
    input logic ackin, input logic ackc);
    if (lost)
      end_code = i2cdc_pkg::SC_ARB;
    else if (mst && aph)
      end_code = rwb ? (ackin ? i2cdc_pkg::SC_AR_A : i2cdc_pkg::SC_AR_N)
                     : (ackin ? i2cdc_pkg::SC_AW_A : i2cdc_pkg::SC_AW_N);
    else if (mst)
      end_code = tx ? (ackin ? i2cdc_pkg::SC_DT_A : i2cdc_pkg::SC_DT_N)
                    : (ackc ? i2cdc_pkg::SC_DR_A : i2cdc_pkg::SC_DR_N);
    else if (aph)
      end_code = gc ? i2cdc_pkg::SC_GC : (rwb ? i2cdc_pkg::SC_SR : i2cdc_pkg::SC_SW);
    else if (tx)
      end_code = !ackc ? i2cdc_pkg::SC_ST_L :
                 (ackin ? i2cdc_pkg::SC_ST_A : i2cdc_pkg::SC_ST_N);
    else if (gc)
      end_code = ackc ? i2cdc_pkg::SC_GD_A : i2cdc_pkg::SC_GD_N;
    else
      end_code = ackc ? i2cdc_pkg::SC_SD_A : i2cdc_pkg::SC_SD_N;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_nxt  = state_r;
    data_nxt   = data_r;
    shift_nxt  = shift_r;
    bit_nxt    = bit_r;
    master_nxt = master_r;
    slave_nxt  = slave_r;
    tx_nxt     = tx_r;
    aph_nxt    = aph_r;
    gc_nxt     = gc_r;
    lost_nxt   = lost_r;
    done_nxt   = done_r;
    moved_nxt  = moved_r;
    ackin_nxt  = ackin_r;
    scl_lo_nxt = scl_lo_r;
    sda_lo_nxt = sda_lo_r;
    cnt_nxt    = (tick | rise | fall) ? 8'h00 : cnt_r + 8'h01;
    evt        = 1'b0;
    evt_code   = i2cdc_pkg::SC_IDLE;
    sta_clr    = 1'b0;
    stp_clr    = 1'b0;
    case (state_r)
      i2cdc_pkg::S_IDLE:
      begin
        scl_lo_nxt = 1'b0;
        sda_lo_nxt = 1'b0;
        master_nxt = 1'b0;
        stp_clr    = ctrl_r.stop_req;
        if (start_det)
        begin
          state_nxt = i2cdc_pkg::S_BIT;
          aph_nxt   = 1'b1;
          tx_nxt    = 1'b0;
          lost_nxt  = 1'b0;
          bit_nxt   = 4'h0;
        end
        else if (ctrl_r.start_req && en && !busy_r)
        begin
          state_nxt  = i2cdc_pkg::S_START;
          sda_lo_nxt = 1'b1;
          cnt_nxt    = 8'h00;
        end
      end
      i2cdc_pkg::S_START:
        if (tick)
        begin
          scl_lo_nxt = 1'b1;
          sta_clr    = 1'b1;
          master_nxt = 1'b1;
          moved_nxt  = 1'b0;
          aph_nxt    = 1'b1;
          tx_nxt     = 1'b1;
          lost_nxt   = 1'b0;
          evt        = 1'b1;
          evt_code   = i2cdc_pkg::SC_STA;
          state_nxt  = i2cdc_pkg::S_WAIT;
        end
      i2cdc_pkg::S_RSTART:
        if (tick)
        begin
          if (!sda_lo_r && scl_lo_r)
            scl_lo_nxt = 1'b0;
          else if (!sda_lo_r && scl_s)
            sda_lo_nxt = 1'b1;
          else if (sda_lo_r)
          begin
            scl_lo_nxt = 1'b1;
            sta_clr    = 1'b1;
            aph_nxt    = 1'b1;
            tx_nxt     = 1'b1;
            moved_nxt  = 1'b0;
            evt        = 1'b1;
            evt_code   = moved_r ? i2cdc_pkg::SC_RSTA : i2cdc_pkg::SC_STA;
            state_nxt  = i2cdc_pkg::S_WAIT;
          end
        end
      i2cdc_pkg::S_STOP:
        if (tick)
        begin
          if (scl_lo_r)
            scl_lo_nxt = 1'b0;
          else if (sda_lo_r && scl_s)
            sda_lo_nxt = 1'b0;
          else if (!sda_lo_r)
          begin
            stp_clr    = 1'b1;
            master_nxt = 1'b0;
            state_nxt  = i2cdc_pkg::S_IDLE;
          end
        end
      i2cdc_pkg::S_WAIT:
        if (!ctrl_r.flag)
        begin
          if (ctrl_r.stop_req)
          begin
            stp_clr   = !master_r;
            state_nxt = master_r ? i2cdc_pkg::S_STOP : i2cdc_pkg::S_IDLE;
            sda_lo_nxt = master_r;
            scl_lo_nxt = master_r;
            cnt_nxt   = 8'h00;
          end
          else if (ctrl_r.start_req && master_r)
          begin
            state_nxt  = i2cdc_pkg::S_RSTART;
            sda_lo_nxt = 1'b0;
            cnt_nxt    = 8'h00;
          end
          else if (done_r || (!master_r && !slave_r && !aph_r))
            state_nxt = i2cdc_pkg::S_IDLE;
          else
          begin
            state_nxt  = i2cdc_pkg::S_BIT;
            bit_nxt    = 4'h0;
            shift_nxt  = data_r;
            sda_lo_nxt = tx_r & ~data_r[7];
            scl_lo_nxt = master_r;
            cnt_nxt    = 8'h00;
          end
        end
      i2cdc_pkg::S_BIT:
      begin
        if (master_r && !lost_r && tick)
          scl_lo_nxt = scl_lo_r ? 1'b0 : (scl_s ? 1'b1 : 1'b0);
        if (master_r && (start_det || stop_det))
        begin
          evt        = 1'b1;
          evt_code   = i2cdc_pkg::SC_BERR;
          master_nxt = 1'b0;
          done_nxt   = 1'b1;
          scl_lo_nxt = 1'b0;
          sda_lo_nxt = 1'b0;
          state_nxt  = i2cdc_pkg::S_WAIT;
        end
        else if (!master_r && (start_det || stop_det))
        begin
          if (slave_r)
          begin
            evt      = 1'b1;
            evt_code = i2cdc_pkg::SC_SSTP;
          end
          slave_nxt  = 1'b0;
          done_nxt   = 1'b1;
          sda_lo_nxt = 1'b0;
          state_nxt  = slave_r ? i2cdc_pkg::S_WAIT : i2cdc_pkg::S_IDLE;
        end
        else if (rise)
        begin
          if (bit_r[3])
            ackin_nxt = ~sda_s;
          else
          begin
            shift_nxt = {shift_r[6:0], sda_s};
            if (master_r && tx_r && !sda_lo_r && !sda_s)
            begin
              lost_nxt   = 1'b1;
              master_nxt = 1'b0;
              scl_lo_nxt = 1'b0;
            end
          end
        end
        else if (fall)
        begin
          if (bit_r < 4'h7)
          begin
            bit_nxt    = bit_r + 4'h1;
            sda_lo_nxt = tx_r & ~lost_r & ~shift_r[7];
          end
          else if (bit_r == 4'h7)
          begin
            bit_nxt  = 4'h8;
            data_nxt = shift_r;
            if (aph_r && !master_r)
            begin
              sda_lo_nxt = addr_hit;
              gc_nxt     = gc_hit;
              if (!addr_hit)
                state_nxt = i2cdc_pkg::S_IDLE;
            end
            else
              sda_lo_nxt = ~tx_r & ~lost_r & ctrl_r.ack_ctl;
          end
          else
          begin
            evt        = 1'b1;
            evt_code   = end_code(lost_r, master_r, aph_r, tx_r, gc_r, rw, ackin_r,
                                  ctrl_r.ack_ctl);
            moved_nxt  = 1'b1;
            sda_lo_nxt = 1'b0;
            scl_lo_nxt = 1'b1;
            state_nxt  = i2cdc_pkg::S_WAIT;
            done_nxt   = lost_r | (!master_r && !aph_r && tx_r && (!ackin_r ||
                         !ctrl_r.ack_ctl));
            if (aph_r)
            begin
              slave_nxt = ~master_r;
              tx_nxt    = master_r ? ~rw : rw & ~gc_r;
            end
            aph_nxt = 1'b0;
          end
        end
      end
      default:
        state_nxt = i2cdc_pkg::S_IDLE;
    endcase
    if (resume && done_r)
      done_nxt = 1'b0;
    if (state_nxt == i2cdc_pkg::S_IDLE)
      slave_nxt = 1'b0;
    if (!en)
    begin
      state_nxt  = i2cdc_pkg::S_IDLE;
      scl_lo_nxt = 1'b0;
      sda_lo_nxt = 1'b0;
      master_nxt = 1'b0;
      slave_nxt  = 1'b0;
      evt        = 1'b0;
    end
    if (req.wr_data && !(state_r == i2cdc_pkg::S_BIT && fall && bit_r == 4'h7))
      data_nxt = req.wdata;
  end

  ////////////////////////////////////////////////////////////////////////
  // Hardware set beats a software clear landing in the same cycle
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (req.wr_ctrl)
    begin
      ctrl_nxt.irq_en  = req.wdata[i2cdc_pkg::IEN_B];
      ctrl_nxt.bus_en  = req.wdata[i2cdc_pkg::BUS_ENABLE_BIT_B];
      ctrl_nxt.ack_ctl = req.wdata[i2cdc_pkg::ACK_B];
    end
    ctrl_nxt.start_req = (ctrl_r.start_req & ~sta_clr) |
                         (req.wr_ctrl & req.wdata[i2cdc_pkg::STA_B]);
    ctrl_nxt.stop_req  = (ctrl_r.stop_req & ~stp_clr) |
                         (req.wr_ctrl & req.wdata[i2cdc_pkg::STP_B]);
    ctrl_nxt.flag      = evt | (ctrl_r.flag & ~flag_clr);
  end
  assign status_nxt = evt ? evt_code :
                      (ctrl_r.flag && !ctrl_nxt.flag) ? i2cdc_pkg::SC_IDLE :
                      status_r;

  always_ff @(posedge i_mclk or negedge rstn_r)
    if (!rstn_r)
    begin
      ctrl_r   <= i2cdc_pkg::CTRL_RST;
      data_r   <= i2cdc_pkg::DATA_RST;
      status_r <= i2cdc_pkg::SC_IDLE;
      state_r  <= i2cdc_pkg::S_IDLE;
      {scl_p_r, sda_p_r, busy_r} <= 3'b110;
      {master_r, slave_r, tx_r, aph_r, gc_r, lost_r, done_r} <= 7'h00;
      {moved_r, ackin_r, scl_lo_r, sda_lo_r} <= 4'h0;
      {shift_r, cnt_r, bit_r} <= 20'h00000;
    end
    else
    begin
      ctrl_r   <= ctrl_nxt;
      data_r   <= data_nxt;
      status_r <= status_nxt;
      state_r  <= state_nxt;
      {scl_p_r, sda_p_r} <= {scl_s, sda_s};
      busy_r   <= en & (start_det | (busy_r & ~stop_det));
      {master_r, slave_r, tx_r, aph_r} <= {master_nxt, slave_nxt, tx_nxt, aph_nxt};
      {gc_r, lost_r, done_r} <= {gc_nxt, lost_nxt, done_nxt};
      {moved_r, ackin_r, scl_lo_r, sda_lo_r} <= {moved_nxt, ackin_nxt, scl_lo_nxt,
                                                 sda_lo_nxt};
      {shift_r, cnt_r, bit_r} <= {shift_nxt, cnt_nxt, bit_nxt};
    end

  // Open drain: both pins only ever pull low
  assign o_scl         = 1'b0;
  assign o_sda         = 1'b0;
  assign o_scl_oen     = ~scl_lo_r;
  assign o_sda_oen     = ~sda_lo_r;
  assign o_irq         = ctrl_r.flag & ctrl_r.irq_en;
  assign o_status_code = status_r;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!rstn_r);

  sequence byte_done_s;
    state_r == i2cdc_pkg::S_BIT && fall && bit_r == 4'h8 && en;
  endsequence
  sequence resume_s;
    resume && en && !ctrl_r.stop_req && !ctrl_r.start_req && !done_r;
  endsequence

  irq_follow_a: assert property ($rose(ctrl_r.flag) |-> o_irq == ctrl_r.irq_en)
    else $error("interrupt does not follow flag and enable");
  irq_masked_a: assert property (!ctrl_r.irq_en |-> !o_irq)
    else $error("interrupt high while masked");
  bus_off_a: assert property (!ctrl_r.bus_en |=> state_r == i2cdc_pkg::S_IDLE
    && o_scl_oen && o_sda_oen)
    else $error("disabled block still active on the bus");
  flag_status_a: assert property ((status_r != i2cdc_pkg::SC_IDLE) == ctrl_r.flag)
    else $error("flag and status code disagree");
  stretch_hold_a: assert property (byte_done_s |=> ctrl_r.flag && !o_scl_oen
    ##1 (!o_scl_oen || !ctrl_r.flag))
    else $error("clock line not held while flag pending");
  clear_idle_a: assert property ($fell(ctrl_r.flag) |-> status_r == i2cdc_pkg::SC_IDLE)
    else $error("status not restored after flag clear");
  msb_first_a: assert property (resume_s ##1 state_r == i2cdc_pkg::S_BIT && tx_r
    |-> sda_lo_r == !data_r[7])
    else $error("first bit driven is not the msb");
  capture_a: assert property (state_r == i2cdc_pkg::S_BIT && fall && bit_r == 4'h7
    && en && !req.wr_data |=> data_r == $past(shift_r))
    else $error("data register missed the bus byte");
  nack_rx_a: assert property (state_r == i2cdc_pkg::S_BIT && fall && bit_r == 4'h7
    && en && !tx_r && !aph_r && !ctrl_r.ack_ctl |=> !sda_lo_r)
    else $error("acknowledge driven with acknowledge control off");
  slave_stop_a: assert property (resume && en && ctrl_r.stop_req && !master_r
    |=> state_r == i2cdc_pkg::S_IDLE && !ctrl_r.stop_req && o_sda_oen)
    else $error("slave stop request drove the bus");
  start_clr_a: assert property (state_r == i2cdc_pkg::S_START && tick && en
    && !req.wr_ctrl |=> !ctrl_r.start_req && master_r)
    else $error("start request not cleared after START");
endmodule

// [tb/i2cdc_peer.sv]
`timescale 1ns/100ps
module i2cdc_peer #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic [7:0] i_tx,
  output logic            o_low,
  output logic      [7:0] o_last
);
  int         cnt = 0;
  logic [7:0] sh;
  logic [7:0] tx;
  logic       sel = 1'b0;
  logic       rd = 1'b0;
  logic       first = 1'b0;
  initial o_low = 1'b0;
  ////////////////////////////////////////////////////////////////////////////////
  // Start reframes; stop or master nack drops selection
  always @(negedge i_sda) if (i_scl)
  begin
    cnt = 0;
    first = 1'b1;
    sel = 1'b0;
  end
  always @(posedge i_sda) if (i_scl) sel = 1'b0;
  always @(posedge i_scl)
  begin
    if (cnt == 8 && rd && i_sda) sel = 1'b0;
    sh = {sh[6:0], i_sda};
    cnt = cnt + 1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Changes only while clock low, so no false start or stop
  always @(negedge i_scl)
  begin
    o_low = 1'b0;
    if (cnt == 9) cnt = 0;
    if (cnt == 8 && first)
    begin
      sel = (sh[7:1] == ADDR);
      rd = sh[0];
      tx = i_tx;
      first = 1'b0;
      o_low = sel;
    end
    else if (cnt == 8)
    begin
      o_last = sh;
      o_low = sel & !rd;
    end
    else if (sel && rd) o_low = !tx[7-cnt];
  end
endmodule

// [tb/test_i2cdc_top.sv]
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module test_i2cdc_top;
  localparam logic [6:0]  PADR = 7'h2a;
  localparam logic [11:0] DA   = i2cdc_pkg::DATA_ADDR;
  localparam logic [11:0] CA   = i2cdc_pkg::CTRL_ADDR;
  logic        clk = 0, rstn = 0, rd = 0, wr = 0, irq, scl_oen, sda_oen, scl_o, sda_o, low;
  logic [11:0] adr = '0;
  logic [31:0] wd = '0, rdata;
  logic        wreq;
  logic [7:0]  st, last, v, tx, qv, q[$];
  int          n_errors = 0, cmp_count = 0, n_start = 0, n_stop = 0, seed = 32;
  // Pull-ups on both lines; peer only ever pulls data low
  wire         scl = (scl_oen === 1'b0) ? scl_o : 1'b1;
  wire         sda = ((sda_oen === 1'b0) ? sda_o : 1'b1) & ~low;
  always #12.5 clk = ~clk;
  i2cdc_top DUT (.i_mclk(clk), .i_rstn(rstn), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'h1),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_own_addr(7'h11),
    .i_gcall_en(1'b0), .i_scl(scl), .o_scl(scl_o), .o_scl_oen(scl_oen), .i_sda(sda),
    .o_sda(sda_o), .o_sda_oen(sda_oen), .o_irq(irq), .o_status_code(st));
  i2cdc_peer #(.ADDR(PADR)) peer (.i_scl(scl), .i_sda(sda), .i_tx(tx), .o_low(low),
    .o_last(last));
  ////////////////////////////////////////////////////////////////////////////////
  // Time-zero line settling must not count as a start or stop
  always @(negedge sda) if (scl === 1'b1 && rstn) n_start++;
  always @(posedge sda) if (scl === 1'b1 && rstn) n_stop++;
  // Oldest note pairs with each accepted read
  always @(posedge clk)
    if (rd && wreq === 1'b0)
    begin
      qv = q.pop_front();
      `CHK(rdata[7:0], qv)
    end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    adr <= a;
    wd <= {24'h0, d};
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wreq !== 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    q.push_back(e);
    xfer(1'b0, a, 8'h00);
  endtask
  task automatic wirq(input logic [7:0] s);
    @(posedge clk);
    while (irq !== 1'b1) @(posedge clk);
    `CHK(st, s)
  endtask
  task automatic stop_test;
    if (n_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Limit of 40000 cycles, well above the several hundred cycles needed
  initial
  begin
    #1000000;
    n_errors++;
    stop_test;
  end
  initial
  begin
    tx = $random(seed);
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(DA, 8'h00);
    rchk(CA, 8'h00);
    xfer(1'b1, CA, 8'h0b);
    rchk(CA, 8'h00);
    v = $random(seed);
    xfer(1'b1, DA, v);
    rchk(DA, v);
    xfer(1'b1, CA, 8'h64);
    while (st !== i2cdc_pkg::SC_STA) @(posedge clk);
    `CHK(irq, 1'b0)
    xfer(1'b1, CA, 8'hcc);
    rchk(CA, 8'hcc);
    `CHK(irq, 1'b1)
    `CHK(scl, 1'b0)
    xfer(1'b1, DA, {PADR, 1'b0});
    xfer(1'b1, CA, 8'hc4);
    wirq(i2cdc_pkg::SC_AW_A);
    v = $random(seed);
    xfer(1'b1, DA, v);
    xfer(1'b1, CA, 8'hc4);
    wirq(i2cdc_pkg::SC_DT_A);
    `CHK(last, v)
    rchk(DA, v);
    xfer(1'b1, CA, 8'he4);
    wirq(i2cdc_pkg::SC_RSTA);
    xfer(1'b1, DA, {PADR, 1'b1});
    xfer(1'b1, CA, 8'hc4);
    wirq(i2cdc_pkg::SC_AR_A);
    xfer(1'b1, CA, 8'hc0);
    wirq(i2cdc_pkg::SC_DR_N);
    rchk(DA, tx);
    xfer(1'b1, CA, 8'hd0);
    while (n_stop == 0) @(posedge clk);
    // Stop request clears one half period after the data line rises
    repeat (2 * i2cdc_pkg::SCL_HALF_CYC) @(posedge clk);
    `CHK(n_stop, 1)
    `CHK(n_start, 2)
    rchk(CA, 8'hc0);
    `CHK(st, i2cdc_pkg::SC_IDLE)
    `CHK(irq, 1'b0)
    stop_test;
  end
endmodule
